/* common/gpio_cfg_pkg.sv */
// gpio value and input function package: register map, fields, resets
// assumes byte-wide registers reached over a 32-bit avalon-mm slave
package gpio_cfg_pkg;

  // ==========================================================
  // register offsets (byte addresses = 4 * index)
  localparam logic [7:0] IDX_OUTPUT_VALUE   = 8'h29;
  localparam logic [7:0] IDX_IO_MONITOR     = 8'h2a;
  localparam logic [7:0] IDX_IN_FUNC_SEL_A  = 8'h2b;
  localparam logic [7:0] IDX_IN_FUNC_SEL_B  = 8'h2c;
  localparam logic [7:0] IDX_PIN_DIRECTION  = 8'h30;

  // ==========================================================
  // field positions
  localparam int BIDIR_VAL_BIT  = 7;
  localparam int OUT_PIN1_BIT   = 6;
  localparam int OUT_PIN4_BIT   = 3;
  localparam int MON_BIT        = 7;
  localparam int DIR_BIDIR_BIT  = 4;
  localparam int FUNC_HI_LSB    = 4;
  localparam int FUNC_LO_LSB    = 0;
  localparam int FUNC_W         = 3;

  // ==========================================================
  // reset values and write masks
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] VALUE_MASK  = 8'hf8;
  localparam logic [7:0] FUNC_RESET  = 8'h00;
  localparam logic [7:0] FUNC_MASK   = 8'h77;
  localparam logic [7:0] DIR_RESET   = 8'h00;
  localparam logic [7:0] DIR_MASK    = 8'h1f;
  localparam logic [7:0] MON_RESET   = 8'h00;

  // ==========================================================
  // input pin function codes
  localparam logic [2:0] FN_DISABLED   = 3'h0;
  localparam logic [2:0] FN_GEN_INPUT  = 3'h1;
  localparam logic [2:0] FN_MCLK       = 3'h2;
  localparam logic [2:0] FN_CHAIN_DATA = 3'h3;
  localparam logic [2:0] FN_PDM_A      = 3'h4;
  localparam logic [2:0] FN_PDM_B      = 3'h5;
  localparam logic [2:0] FN_PDM_C      = 3'h6;
  localparam logic [2:0] FN_PDM_D      = 3'h7;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage

/* hw/input_function_decode.sv */
// decodes one input pin's 3-bit function field into one-hot selects
// assumes the field comes from a register and the pin is synchronous
`timescale 1ns/100ps
module input_function_decode
  import gpio_cfg_pkg::*;
(
  // function field
  input  wire logic [2:0] i_function,
  // decoded selects
  output logic            o_gen_input,
  output logic            o_mclk,
  output logic            o_chain_data,
  output logic [3:0]      o_pdm
);

  // ==========================================================
  // decode, every code yields exactly one or no select
  always_comb begin
    o_gen_input  = 1'b0;
    o_mclk       = 1'b0;
    o_chain_data = 1'b0;
    o_pdm        = 4'h0;
    case (i_function)
      FN_DISABLED:   o_gen_input  = 1'b0; // RQ4
      FN_GEN_INPUT:  o_gen_input  = 1'b1; // RQ4
      FN_MCLK:       o_mclk       = 1'b1; // RQ4
      FN_CHAIN_DATA: o_chain_data = 1'b1; // RQ4
      FN_PDM_A:      o_pdm[0]     = 1'b1; // RQ5
      FN_PDM_B:      o_pdm[1]     = 1'b1; // RQ5
      FN_PDM_C:      o_pdm[2]     = 1'b1; // RQ5
      FN_PDM_D:      o_pdm[3]     = 1'b1; // RQ5
      default:       o_gen_input  = 1'b0;
    endcase
  end

endmodule

/* hw/pin_route_mux.sv */
// routes the four input pins onto the functions chosen for them
// assumes one-hot selects per pin; lowest pin wins on a conflict
`timescale 1ns/100ps
module pin_route_mux #(
  parameter int PINS = 4
) (
  // pin levels and per-pin selects
  input  wire logic [PINS-1:0] i_pins,
  input  wire logic [PINS-1:0] i_sel,
  // routed level and presence flag
  output logic                 o_level,
  output logic                 o_any
);

  // ==========================================================
  // priority pick: two pins on one function is a software slip
  always_comb begin
    o_level = 1'b0;
    o_any   = 1'b0;
    for (int p = PINS - 1; p >= 0; p--) begin
      if (i_sel[p]) begin
        o_level = i_pins[p];
        o_any   = 1'b1;
      end
    end
  end

endmodule

/* hw/gpio_value_and_input_config.sv */
// gpio value, monitor and input function registers with pin routing
// assumes avalon-mm master on i_clock, pins synchronous to i_clock
//
// Summary of operation
// RQ1: bidirectional pin as output drives output value bit 7.
// RQ2: output pins one to four drive value bits 6, 5, 4, 3.
// RQ3: monitor bit 7 shows bidirectional pin input level; other bits zero.
// RQ4: input function codes 0-3: disabled, input, master clock, chain data.
// RQ5: codes 4-7 route pin to pdm data for pairs 1-2 to 7-8.
// RQ6: input pin two function sits in bits 2-0 of select a.
// RQ7: input pin three in bits 6-4 of select b; bits 7,3 reserved.
// RQ8: all value, monitor and function fields reset to zero.
// RQ9: input pin four function sits in bits 2-0 of select b.
// RQ10: reserved bits ignore writes and read back zero.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module gpio_value_and_input_config
  import gpio_cfg_pkg::*;
#(
  parameter int IN_PINS  = 4,
  parameter int OUT_PINS = 4
) (
  // clock, reset, enable
  input  wire logic                i_clock,
  input  wire logic                i_reset_n,
  input  wire logic                i_clk_en,
  // avalon-mm slave
  input  wire logic [9:0]          i_address,
  input  wire logic                i_read,
  input  wire logic                i_write,
  input  wire logic [31:0]         i_writedata,
  input  wire logic [3:0]          i_byteenable,
  output logic [31:0]              o_readdata,
  output logic                     o_waitrequest,
  output logic [1:0]               o_response,
  // bidirectional pin
  input  wire logic                i_bidir_pin,
  output logic                     o_bidir_pin,
  output logic                     o_bidir_pin_oe,
  // output-only pins
  output logic [OUT_PINS-1:0]      o_out_pins,
  output logic [OUT_PINS-1:0]      o_out_pins_en,
  // input pins and routed functions
  input  wire logic [IN_PINS-1:0]  i_in_pins,
  output logic [IN_PINS-1:0]       o_in_general_level,
  output logic                     o_mclk,
  output logic                     o_mclk_valid,
  output logic                     o_chain_audio_data_in,
  output logic                     o_chain_valid,
  output logic [3:0]               o_pdm_data_in,
  output logic [3:0]               o_pdm_valid
);

  // ==========================================================
  // registers
  logic [7:0]       output_value_ff;
  logic [7:0]       io_monitor_ff;
  logic [7:0]       in_func_sel_a_ff;
  logic [7:0]       in_func_sel_b_ff;
  logic [7:0]       pin_direction_ff;
  bus_state_t       bus_state_ff;
  logic [7:0]       nxt_rdata;
  logic             hit;
  logic [7:0]       idx;
  logic             wr_lane0;
  logic [7:0]       wdata;

  assign idx      = i_address[9:2];
  assign wr_lane0 = i_write && i_byteenable[0];
  assign wdata    = i_writedata[7:0];

  // address decode; unmapped offsets answer with a slave error
  always_comb begin
    hit       = 1'b1;
    nxt_rdata = 8'h00;
    case (idx)
      IDX_OUTPUT_VALUE:  nxt_rdata = output_value_ff;
      IDX_IO_MONITOR:    nxt_rdata = io_monitor_ff;
      IDX_IN_FUNC_SEL_A: nxt_rdata = in_func_sel_a_ff;
      IDX_IN_FUNC_SEL_B: nxt_rdata = in_func_sel_b_ff;
      IDX_PIN_DIRECTION: nxt_rdata = pin_direction_ff;
      default:           hit = 1'b0;
    endcase
  end

  // ==========================================================
  // bus handshake: one wait cycle, answer on the second edge
  logic take;
  assign take = (bus_state_ff == BUS_IDLE) && (i_read || i_write);

  // state: a taken request always spends exactly one answer cycle
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      bus_state_ff <= BUS_IDLE;
    end else if (i_clk_en) begin
      case (bus_state_ff)
        BUS_IDLE: begin
          if (take) begin
            bus_state_ff <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state_ff <= BUS_IDLE;
        end
        default: begin
          bus_state_ff <= BUS_IDLE;
        end
      endcase
    end
  end

  // waitrequest drops for the answer cycle only, so the request
  // is still up at the edge where the master sees it low
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_waitrequest <= 1'b1;
    end else if (i_clk_en) begin
      o_waitrequest <= !take;
    end
  end

  // read data and response latched as the request is taken
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_readdata <= 32'h00000000;
      o_response <= 2'h0;
    end else if (i_clk_en && take) begin
      o_readdata <= {24'h000000, nxt_rdata};
      o_response <= hit ? 2'h0 : 2'h2;
    end
  end

  // write strobe taken in the cycle the request is accepted
  logic wr_go;
  assign wr_go = take && wr_lane0;

  // ==========================================================
  // output value register, reserved low bits masked off
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      output_value_ff <= VALUE_RESET; // RQ8
    end else if (i_clk_en && wr_go && idx == IDX_OUTPUT_VALUE) begin
      output_value_ff <= wdata & VALUE_MASK; // RQ10
    end
  end

  // function select registers; bits 7 and 3 stay zero
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      in_func_sel_a_ff <= FUNC_RESET; // RQ8
      in_func_sel_b_ff <= FUNC_RESET; // RQ8
    end else if (i_clk_en && wr_go) begin
      if (idx == IDX_IN_FUNC_SEL_A) begin
        in_func_sel_a_ff <= wdata & FUNC_MASK; // RQ7
      end
      if (idx == IDX_IN_FUNC_SEL_B) begin
        in_func_sel_b_ff <= wdata & FUNC_MASK; // RQ10
      end
    end
  end

  // direction register: bit 4 bidir as output, bits 3-0 out pins on
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pin_direction_ff <= DIR_RESET;
    end else if (i_clk_en && wr_go && idx == IDX_PIN_DIRECTION) begin
      pin_direction_ff <= wdata & DIR_MASK;
    end
  end

  // ==========================================================
  // monitor: sampled only while the bidir pin is a general input
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      io_monitor_ff <= MON_RESET; // RQ8
    end else if (i_clk_en) begin
      if (!pin_direction_ff[DIR_BIDIR_BIT]) begin
        io_monitor_ff <= {i_bidir_pin, 7'h00}; // RQ3
      end
    end
  end

  // ==========================================================
  // pin drivers, registered so outputs come straight from flops
  // bidirectional pin: value and enable move on the same edge
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_bidir_pin    <= 1'b0;
      o_bidir_pin_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_bidir_pin    <= output_value_ff[BIDIR_VAL_BIT]; // RQ1
      o_bidir_pin_oe <= pin_direction_ff[DIR_BIDIR_BIT];
    end
  end

  // output-only pins: [3] is pin one, down to [0] for pin four
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_out_pins    <= '0;
      o_out_pins_en <= '0;
    end else if (i_clk_en) begin
      o_out_pins    <= output_value_ff[OUT_PIN1_BIT:OUT_PIN4_BIT]; // RQ2
      o_out_pins_en <= pin_direction_ff[OUT_PINS-1:0];
    end
  end

  // ==========================================================
  // per-pin function decode
  logic [2:0]         pin_func [IN_PINS];
  logic [IN_PINS-1:0] sel_gen;
  logic [IN_PINS-1:0] sel_mclk;
  logic [IN_PINS-1:0] sel_chain;
  logic [3:0]         sel_pdm [IN_PINS];

  assign pin_func[0] = in_func_sel_a_ff[FUNC_HI_LSB +: FUNC_W]; // RQ4
  assign pin_func[1] = in_func_sel_a_ff[FUNC_LO_LSB +: FUNC_W]; // RQ6
  assign pin_func[2] = in_func_sel_b_ff[FUNC_HI_LSB +: FUNC_W]; // RQ7
  assign pin_func[3] = in_func_sel_b_ff[FUNC_LO_LSB +: FUNC_W]; // RQ9

  genvar gp;
  generate
    for (gp = 0; gp < IN_PINS; gp++) begin : g_dec
      input_function_decode u_dec (
        .i_function   (pin_func[gp]),
        .o_gen_input  (sel_gen[gp]),
        .o_mclk       (sel_mclk[gp]),
        .o_chain_data (sel_chain[gp]),
        .o_pdm        (sel_pdm[gp])
      );
    end
  endgenerate

  // ==========================================================
  // routing of pins onto functions
  logic       mclk_lvl;
  logic       mclk_any;
  logic       chain_lvl;
  logic       chain_any;
  logic [3:0] pdm_lvl;
  logic [3:0] pdm_any;

  pin_route_mux #(.PINS(IN_PINS)) u_mclk (
    .i_pins  (i_in_pins),
    .i_sel   (sel_mclk),
    .o_level (mclk_lvl),
    .o_any   (mclk_any)
  );

  pin_route_mux #(.PINS(IN_PINS)) u_chain (
    .i_pins  (i_in_pins),
    .i_sel   (sel_chain),
    .o_level (chain_lvl),
    .o_any   (chain_any)
  );

  genvar gq;
  generate
    for (gq = 0; gq < 4; gq++) begin : g_pdm
      logic [IN_PINS-1:0] col;
      for (genvar gr = 0; gr < IN_PINS; gr++) begin : g_col
        assign col[gr] = sel_pdm[gr][gq];
      end
      pin_route_mux #(.PINS(IN_PINS)) u_pdm (
        .i_pins  (i_in_pins),
        .i_sel   (col),
        .o_level (pdm_lvl[gq]),
        .o_any   (pdm_any[gq])
      );
    end
  endgenerate

  // general inputs; disabled or otherwise routed pins read as low
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_in_general_level <= '0;
    end else if (i_clk_en) begin
      o_in_general_level <= i_in_pins & sel_gen; // RQ4
    end
  end

  // master clock input and its presence flag
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_mclk       <= 1'b0;
      o_mclk_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_mclk       <= mclk_lvl; // RQ4
      o_mclk_valid <= mclk_any;
    end
  end

  // daisy-chain audio data input and its presence flag
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_chain_audio_data_in <= 1'b0;
      o_chain_valid         <= 1'b0;
    end else if (i_clk_en) begin
      o_chain_audio_data_in <= chain_lvl; // RQ4
      o_chain_valid         <= chain_any;
    end
  end

  // pdm data inputs, one per channel pair, with presence flags
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_pdm_data_in <= 4'h0;
      o_pdm_valid   <= 4'h0;
    end else if (i_clk_en) begin
      o_pdm_data_in <= pdm_lvl; // RQ5
      o_pdm_valid   <= pdm_any; // RQ5
    end
  end

endmodule

/* testbench/gpio_value_and_input_config_asserts.sv */
// checker: bus answer, pin drive, readback and routing of the gpio block
// assumes binding to the top module; enable only dropped on an idle bus
`timescale 1ns/100ps
module gpio_value_and_input_config_asserts #(
  parameter int IN_PINS  = 4,
  parameter int OUT_PINS = 4
) (
  // clock and bus
  input wire logic                i_clock,
  input wire logic                i_reset_n,
  input wire logic                i_clk_en,
  input wire logic [9:0]          i_address,
  input wire logic                i_read,
  input wire logic                i_write,
  input wire logic [31:0]         i_writedata,
  input wire logic [3:0]          i_byteenable,
  input wire logic [31:0]         o_readdata,
  input wire logic                o_waitrequest,
  input wire logic [1:0]          o_response,
  // pins
  input wire logic                i_bidir_pin,
  input wire logic                o_bidir_pin,
  input wire logic                o_bidir_pin_oe,
  input wire logic [OUT_PINS-1:0] o_out_pins,
  input wire logic [OUT_PINS-1:0] o_out_pins_en,
  input wire logic [IN_PINS-1:0]  i_in_pins,
  input wire logic [IN_PINS-1:0]  o_in_general_level,
  // routed functions
  input wire logic                o_mclk,
  input wire logic                o_mclk_valid,
  input wire logic                o_chain_audio_data_in,
  input wire logic                o_chain_valid,
  input wire logic [3:0]          o_pdm_data_in,
  input wire logic [3:0]          o_pdm_valid
);
  // ==========================================================
  // handshake helpers
  wire logic       ack = (i_read || i_write) && !o_waitrequest;
  wire logic [7:0] idx = i_address[9:2];
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence req_s; (i_read || i_write) && o_waitrequest; endsequence
  sequence ans_s; !o_waitrequest ##1 o_waitrequest; endsequence
  // pin must sit still a while so any sampling depth settles
  sequence quiet_s; (!o_bidir_pin_oe && $stable(i_bidir_pin)) [*4];
  endsequence
  sequence wval_s; ack && i_write && idx == 8'h29 && i_byteenable[0];
  endsequence
  // ==========================================================
  // properties
  AST_ANSWER: assert property (req_s |=> ans_s)
    else $error("request not answered after one wait");
  AST_BIDIR_DRIVE: assert property (
    wval_s |=> o_bidir_pin == $past(i_writedata[7]))
    else $error("bidir drive differs from value bit 7");
  AST_OUT_DRIVE: assert property (
    wval_s |=> o_out_pins == $past(i_writedata[6:3]))
    else $error("output pins differ from value bits 6 to 3");
  AST_MON_ZERO: assert property (
    ack && i_read && idx == 8'h2a |-> (o_readdata & 32'hffffff7f) == 0)
    else $error("monitor low bits not zero");
  AST_MON_LEVEL: assert property (
    quiet_s ##0 (ack && i_read && idx == 8'h2a)
      |-> o_readdata[7] == i_bidir_pin)
    else $error("monitor bit differs from pin level");
  AST_SEL_RSV: assert property (
    ack && i_read && idx inside {8'h2b, 8'h2c}
      |-> (o_readdata & 32'hffffff88) == 0)
    else $error("select reserved bits not zero");
  AST_VAL_RSV: assert property (
    ack && i_read && idx == 8'h29 |-> o_readdata[2:0] == 3'h0)
    else $error("value reserved bits not zero");
  AST_GEN_LEVEL: assert property (
    $past(i_clk_en) |-> (o_in_general_level & ~$past(i_in_pins)) == 0)
    else $error("general level high while pin was low");
  AST_RESET_ZERO: assert property (
    $rose(i_reset_n) |-> o_out_pins == 0 && !o_bidir_pin
      && o_waitrequest && o_in_general_level == 0 && o_pdm_valid == 0)
    else $error("outputs not zero after reset");
  // a low enable must freeze waitrequest, the output pins, the general levels and the pdm flags
  AST_FREEZE: assert property (
    !i_clk_en |=> $stable(o_waitrequest) && $stable(o_out_pins)
      && $stable(o_in_general_level) && $stable(o_pdm_valid))
    else $error("outputs moved while clock enable was low");
endmodule

bind gpio_value_and_input_config gpio_value_and_input_config_asserts #(
  .IN_PINS(IN_PINS), .OUT_PINS(OUT_PINS)) chk_i (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
  .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_writedata(i_writedata), .i_byteenable(i_byteenable),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_response(o_response), .i_bidir_pin(i_bidir_pin),
  .o_bidir_pin(o_bidir_pin), .o_bidir_pin_oe(o_bidir_pin_oe),
  .o_out_pins(o_out_pins), .o_out_pins_en(o_out_pins_en),
  .i_in_pins(i_in_pins), .o_in_general_level(o_in_general_level),
  .o_mclk(o_mclk), .o_mclk_valid(o_mclk_valid),
  .o_chain_audio_data_in(o_chain_audio_data_in),
  .o_chain_valid(o_chain_valid), .o_pdm_data_in(o_pdm_data_in),
  .o_pdm_valid(o_pdm_valid));

/* testbench/gpio_value_and_input_config_tb_top.sv */
// bench: bus, pin drive and routing checks against an integer model
// assumes the checker binds itself; enable dropped once with the bus idle
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  err_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module gpio_value_and_input_config_tb_top;
  import gpio_cfg_pkg::*;
  // ==========================================================
  // signals and model state
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, bpin = 0, b1, cen = 1;
  logic        wt, bo, boe, mc, mcv, ch, chv;
  logic [9:0]  addr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [3:0]  be = '0, ipin = '0, opin, oen, gen, pdm, pdv, lastg;
  logic [1:0]  resp;
  logic [7:0]  ids [7] = '{8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h30, 8'h00, 8'h31};
  int          err_count = 0, checks_done = 0, cyc = 0;
  int          mval = 0, msa = 0, msb = 0, mdir = 0, mmon = 0;

  gpio_value_and_input_config gpio_value_and_input_config_i (
    .i_clock(clk), .i_reset_n(rst_n), .i_clk_en(cen),
    .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdat),
    .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wt),
    .o_response(resp), .i_bidir_pin(bpin), .o_bidir_pin(bo),
    .o_bidir_pin_oe(boe), .o_out_pins(opin), .o_out_pins_en(oen),
    .i_in_pins(ipin), .o_in_general_level(gen), .o_mclk(mc),
    .o_mclk_valid(mcv), .o_chain_audio_data_in(ch), .o_chain_valid(chv),
    .o_pdm_data_in(pdm), .o_pdm_valid(pdv));

  // clock and hang guard; 20000 cycles is far beyond the run's needs
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // one bus access; expected answer comes from the model
  task automatic acc(input bit w, input logic [7:0] i, d, input logic [3:0] b);
    int e;
    @(posedge clk);
    wr <= w; rd <= !w; addr <= {i, 2'b00}; wdat <= {24'h0, d}; be <= b;
    do @(posedge clk); while (wt !== 1'b0);
    e = i == 8'h29 ? mval : i == 8'h2a ? mmon : i == 8'h2b ? msa :
        i == 8'h2c ? msb : i == 8'h30 ? mdir : 0;
    if (!w) `CHK(rdat, 32'(e))
    `CHK(resp, i inside {8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h30} ? 2'h0 : 2'h2)
    if (w && b[0]) case (i)
      8'h29: mval = d & 8'hf8;
      8'h2b: msa = d & 8'h77;
      8'h2c: msb = d & 8'h77;
      8'h30: mdir = d & 8'h1f;
      default: ;
    endcase
    wr <= 0; rd <= 0;
  endtask

  task automatic pins();
    @(negedge clk);
    `CHK(bo, mval[7])
    `CHK(opin, mval[6:3])
    `CHK({boe, oen}, mdir[4:0])
  endtask

  // routed outputs lag the pins by one edge
  task automatic route();
    logic [7:0] lv, vd;
    logic [3:0] g;
    int c;
    @(posedge clk); @(negedge clk);
    lv = 0; vd = 0; g = 0;
    for (int p = 0; p < 4; p++) begin
      c = ((p < 2 ? msa : msb) >> (p[0] ? 0 : 4)) & 7;
      if (c == 1) g[p] = ipin[p];
      if (c > 1 && !vd[c]) begin
        vd[c] = 1; lv[c] = ipin[p];
      end
    end
    lastg = g;
    `CHK(gen, g)
    `CHK({mc, mcv, ch, chv}, {lv[2], vd[2], lv[3], vd[3]})
    `CHK({pdm, pdv}, {lv[7:4], vd[7:4]})
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(44));
    repeat (16) @(posedge clk);
    rst_n <= 1;
    foreach (ids[k]) acc(0, ids[k], 8'h00, 4'h1);
    pins();
    acc(1, 8'h30, 8'hff, 4'h1);
    repeat (8) begin
      acc(1, 8'h29, 8'($urandom), 4'h1);
      pins();
      acc(0, 8'h29, 8'h00, 4'h1);
    end
    // no lane, read-only and unmapped writes must change nothing
    acc(1, 8'h29, 8'hff, 4'he);
    acc(1, 8'h2a, 8'hff, 4'h1);
    acc(1, 8'h31, 8'hff, 4'h1);
    acc(0, 8'h29, 8'h00, 4'h1);
    repeat (40) begin
      acc(1, 8'h2b, 8'($urandom), 4'h1);
      acc(1, 8'h2c, 8'($urandom), 4'h1);
      acc(0, 8'h2b, 8'h00, 4'h1);
      acc(0, 8'h2c, 8'h00, 4'h1);
      repeat (4) begin
        @(posedge clk);
        ipin <= 4'($urandom);
        route();
      end
    end
    // all pins general, then a low enable must hold the old levels
    acc(1, 8'h2b, 8'h11, 4'h1);
    acc(1, 8'h2c, 8'h11, 4'h1);
    @(posedge clk);
    ipin <= 4'($urandom);
    route();
    @(posedge clk);
    cen <= 0;
    ipin <= ~ipin;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(gen, lastg)
    @(posedge clk);
    cen <= 1;
    route();
    // bidir back to input so the monitor follows it
    acc(1, 8'h30, 8'h00, 4'h1);
    repeat (8) begin
      b1 = 1'($urandom);
      @(posedge clk);
      bpin <= b1;
      repeat (4) @(posedge clk);
      mmon = b1 ? 8'h80 : 0;
      acc(0, 8'h2a, 8'h00, 4'h1);
    end
    wrap_up();
  end
endmodule
